// ==== rtl/pccsig_socket.sv ====
/*
 * pccsig_socket.sv: first bus control register on an AHB-Lite slave, plus the card
 * socket signal map for areas five and six, with a simple card access engine.
 * assumes one 25 MHz clock, inputs synchronous to it, power-on reset on reset,
 * manual reset on manualReset which leaves the control register alone.
 */
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pccsig_defs.svh"
module pccsig_socket #(
  parameter int STROBE_CYCLES = `PCCSIG_STROBE_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 manualReset,
  input  wire logic                 standby,
  input  wire logic                 endianPin,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 cardReq,
  input  wire logic                 cardWrite,
  input  wire logic                 cardIo,
  input  wire logic [28:0]          cardAddr,
  input  wire pccsig_pkg::pccsig_word_t cardWdata,
  output logic                      cardDone,
  output pccsig_pkg::pccsig_word_t  cardRdata,
  output logic                      cardWide,
  output logic      [24:0]          cardA,
  output logic                      cardAOe_n,
  input  wire logic [15:0]          cardDIn,
  output logic      [15:0]          cardDOut,
  output logic                      cardDOe_n,
  output logic                      area_five_select_n,
  output logic                      area_six_select_n,
  output logic                      readStrobe_n,
  output logic                      lane_one_write_strobe_n,
  output logic                      strobeOe_n,
  output logic                      mode_pin_three_n,
  output logic                      mode_pin_four_n,
  output logic                      card_io_read_strobe_n,
  output logic                      card_io_write_strobe_n,
  input  wire logic                 ioIs16_n,
  input  wire logic                 cardWait_n,
  input  wire logic                 readyBusy,
  input  wire logic                 statusChange,
  input  wire logic                 batteryAudio,
  input  wire logic                 cardDetect1_n,
  input  wire logic                 cardDetect2_n,
  output logic                      attrSelect_n,
  output logic                      cardReset,
  output logic                      refresh_n,
  output logic                      topAddr
);
  import pccsig_pkg::*;

  initial begin
    if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin
      $error("STROBE_CYCLES out of range");
    end
  end

  pccsig_word_t  ctrl;
  logic [3:0]    genOut;
  logic [4:0]    senseIn;
  logic          endianLoad;
  logic          dphValid;
  logic          dphWrite;
  logic [31:0]   dphAddr;
  pccsig_state_t state;
  logic [7:0]    strobeCnt;
  logic          curFive;
  logic          curWrite;
  logic          curIo;
  logic          driveMem;
  logic          cardArea5;
  logic          cardArea6;
  logic [2:0]    reqArea;

  assign reqArea   = cardAddr[28:26];
  assign cardArea5 = (reqArea == `PCCSIG_AREA_FIVE) && ctrl[`PCCSIG_B_A5CARD];
  assign cardArea6 = (reqArea == `PCCSIG_AREA_SIX) && ctrl[`PCCSIG_B_A6CARD];
  assign driveMem  = !standby || ctrl[`PCCSIG_B_STBYMEM];

  // address phase capture; slave is always ready, so zero wait states
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dphValid <= 1'b0;
      dphWrite <= 1'b0;
      dphAddr  <= 32'h0000_0000;
    end else begin
      dphValid <= hsel && hready && htrans[1];
      dphWrite <= hwrite;
      // full address kept so that unmapped words do not alias onto the control register
      dphAddr  <= haddr;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // endian pin is caught on the first clock after power-on reset, never in the reset branch
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      endianLoad <= 1'b1;
    end else begin
      endianLoad <= 1'b0;
    end
  end

  // power-on reset only; manual reset leaves it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `PCCSIG_CTRL_RESET;
    end else if (endianLoad) begin
      ctrl[`PCCSIG_B_ENDIAN] <= endianPin;
    end else if (dphValid && dphWrite && dphAddr == `PCCSIG_CTRL_OFFSET) begin
      // reserved bits forced zero; endian kept read-only
      ctrl <= (hwdata[15:0] & `PCCSIG_CTRL_WMASK) | (ctrl & ~`PCCSIG_CTRL_WMASK & 16'h0800);
    end
  end

  // general output port for attribute, reset, refresh, top address
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      genOut <= 4'h0;
    end else if (manualReset) begin
      genOut <= 4'h0;
    end else if (dphValid && dphWrite && dphAddr == `PCCSIG_PORT_OFFSET) begin
      genOut <= hwdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      attrSelect_n <= 1'b1;
      cardReset    <= 1'b0;
      refresh_n    <= 1'b1;
      topAddr      <= 1'b0;
    end else begin
      attrSelect_n <= ~genOut[`PCCSIG_P_ATTR];
      cardReset    <= genOut[`PCCSIG_P_CARDRESET];
      refresh_n    <= ~genOut[`PCCSIG_P_REFRESH];
      topAddr      <= genOut[`PCCSIG_P_TOPADDR];
    end
  end

  // general input port samples; ready/busy sensed here only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      senseIn <= 5'h00;
    end else begin
      senseIn <= {cardDetect2_n, cardDetect1_n, batteryAudio, statusChange, readyBusy};
    end
  end

  // no write-protect input exists; nothing to handle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr)
        `PCCSIG_CTRL_OFFSET: hrdata <= {16'h0000, ctrl};
        `PCCSIG_PORT_OFFSET: hrdata <= {28'h0000000, genOut};
        `PCCSIG_STAT_OFFSET: hrdata <= {27'h0000000, senseIn};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // card access engine: idle, strobe (stretched by wait), done
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state     <= PCCSIG_IDLE;
      strobeCnt <= 8'h00;
      curFive   <= 1'b0;
      curWrite  <= 1'b0;
      curIo     <= 1'b0;
      cardDone  <= 1'b0;
      cardRdata <= 16'h0000;
      cardWide  <= 1'b0;
    end else if (manualReset) begin
      state    <= PCCSIG_IDLE;
      cardDone <= 1'b0;
    end else begin
      cardDone <= 1'b0;
      case (state)
        PCCSIG_IDLE: begin
          if (cardReq && (cardArea5 || cardArea6)) begin
            state     <= PCCSIG_STROBE;
            strobeCnt <= 8'(STROBE_CYCLES);
            curFive   <= cardArea5;
            curWrite  <= cardWrite;
            // area five serves memory cards only
            curIo     <= cardIo && cardArea6;
          end
        end
        PCCSIG_STROBE: begin
          if (strobeCnt > 8'h01) begin
            strobeCnt <= strobeCnt - 8'h01;
          end else if (cardWait_n) begin
            state <= PCCSIG_DONE;
            cardRdata <= cardDIn;
            cardWide  <= curIo ? !ioIs16_n : 1'b1;
          end
        end
        PCCSIG_DONE: begin
          state    <= PCCSIG_IDLE;
          cardDone <= 1'b1;
        end
        default: state <= PCCSIG_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      area_five_select_n      <= 1'b1;
      area_six_select_n       <= 1'b1;
      readStrobe_n            <= 1'b1;
      lane_one_write_strobe_n <= 1'b1;
      card_io_read_strobe_n   <= 1'b1;
      card_io_write_strobe_n  <= 1'b1;
      mode_pin_three_n        <= 1'b1;
      mode_pin_four_n         <= 1'b1;
      cardA                   <= 25'h0000000;
      cardDOut                <= 16'h0000;
      cardDOe_n               <= 1'b1;
      cardAOe_n               <= 1'b1;
      strobeOe_n              <= 1'b1;
    end else begin
      // card enable one from area select
      area_five_select_n <= !(state == PCCSIG_STROBE && curFive);
      area_six_select_n  <= !(state == PCCSIG_STROBE && !curFive);
      readStrobe_n            <= !(state == PCCSIG_STROBE && !curWrite && !curIo);
      lane_one_write_strobe_n <= !(state == PCCSIG_STROBE && curWrite && !curIo);
      card_io_read_strobe_n   <= !(state == PCCSIG_STROBE && !curWrite && curIo);
      card_io_write_strobe_n  <= !(state == PCCSIG_STROBE && curWrite && curIo);
      // second enable per area; only in card mode
      mode_pin_three_n <= !(state == PCCSIG_STROBE && curFive && ctrl[`PCCSIG_B_A5CARD]);
      mode_pin_four_n  <= !(state == PCCSIG_STROBE && !curFive && ctrl[`PCCSIG_B_A6CARD]);
      if (state == PCCSIG_IDLE && cardReq) begin
        cardA    <= cardAddr[24:0];
        cardDOut <= cardWdata;
      end
      cardDOe_n  <= !(state == PCCSIG_STROBE && curWrite);
      // float in standby unless kept driven
      cardAOe_n  <= !driveMem;
      strobeOe_n <= !driveMem;
    end
  end

  property p_one_select;
    @(posedge sys_clk) disable iff (reset)
      !(!area_five_select_n && !area_six_select_n);
  endproperty
  a_one_select: assert property (p_one_select) else $error("both area selects active");

  property p_power_on_zero;
    @(posedge sys_clk) disable iff (reset)
      $fell(endianLoad) |-> (ctrl & 16'hf7ff) == 16'h0000;
  endproperty
  a_power_on_zero: assert property (p_power_on_zero) else $error("control not zero after reset");

  property p_endian_load;
    @(posedge sys_clk) disable iff (reset)
      endianLoad |=> ctrl[`PCCSIG_B_ENDIAN] == $past(endianPin);
  endproperty
  a_endian_load: assert property (p_endian_load) else $error("endian flag not loaded");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (reset)
      ctrl[15:14] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_standby_float;
    @(posedge sys_clk) disable iff (reset)
      standby && !ctrl[`PCCSIG_B_STBYMEM] |=> cardAOe_n && strobeOe_n;
  endproperty
  a_standby_float: assert property (p_standby_float) else $error("memory pins driven in standby");

  property p_wait_holds;
    @(posedge sys_clk) disable iff (reset || manualReset)
      state == PCCSIG_STROBE && strobeCnt <= 8'h01 && !cardWait_n |=> state == PCCSIG_STROBE;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait not honoured");

  property p_io_strobe_area;
    @(posedge sys_clk) disable iff (reset)
      !card_io_read_strobe_n || !card_io_write_strobe_n |-> !area_six_select_n;
  endproperty
  a_io_strobe_area: assert property (p_io_strobe_area) else $error("io strobe outside area six");

  property p_second_enable;
    @(posedge sys_clk) disable iff (reset)
      !mode_pin_three_n |-> !area_five_select_n && ctrl[`PCCSIG_B_A5CARD];
  endproperty
  a_second_enable: assert property (p_second_enable) else $error("second enable without card mode");

  property p_second_enable_six;
    @(posedge sys_clk) disable iff (reset)
      !mode_pin_four_n |-> !area_six_select_n && ctrl[`PCCSIG_B_A6CARD];
  endproperty
  a_second_enable_six: assert property (p_second_enable_six) else $error("area six enable wrong");

endmodule : pccsig_socket

// ==== rtl/pccsig_defs.svh ====
/*
 * pccsig_defs.svh: offsets, field positions, reset values and timing counts for the
 * card-socket signal map and first bus control register.
 * assumes inclusion once per compile unit; guarded against double inclusion.
 */
//
// Overview of operation
// - card enable one comes from area-five or area-six chip select
// - card output enable is driven from the read strobe
// - card write enable is driven from the lane-one write strobe
// - ready/busy or interrupt request is only sensed through a general input port
// - card's 16-bit port indication is taken on its own input and sizes I/O access
// - card enable two comes from a secondary enable output per area
// - I/O read and write strobes are dedicated outputs for card I/O cycles only
// - card wait request stretches the current access while asserted
// - attribute select, card reset, refresh and top address come from general outputs
// - status change, battery/audio and card detects are sensed through general inputs
// - write protect output of the card is not handled
// - card address 0..24 driven by device address lines of same index
// - card data 0..15 connect both ways to device data lines of same index
// - control register is 16-bit, zero at power-on reset, kept through manual reset
// - endian flag bit 11 loaded from endian pin at power-on reset
// - bits 15 and 14 read zero and are written as zero
// - bit 13 picks standby state of address, strobes, selects and secondary enables; here it gates only cardAOe_n and strobeOe_n
// - fixed layout of standby, endian, burst, memory type and card enable fields
// - bit 13 zero floats the memory signals in standby, one keeps them driven
// - bit 1 makes area five card space and mode pin three its second enable
// - bit 0 makes area six card space and mode pin four its second enable
`ifndef PCCSIG_DEFS_SVH
`define PCCSIG_DEFS_SVH
`define PCCSIG_CTRL_OFFSET   32'h0000_0000
`define PCCSIG_PORT_OFFSET   32'h0000_0004
`define PCCSIG_STAT_OFFSET   32'h0000_0008
`define PCCSIG_CTRL_RESET    16'h0000
`define PCCSIG_CTRL_WMASK    16'h37ff
`define PCCSIG_B_STBYMEM     13
`define PCCSIG_B_STBYROWCOL  12
`define PCCSIG_B_ENDIAN      11
`define PCCSIG_B_A0BURST     9
`define PCCSIG_B_A5BURST     7
`define PCCSIG_B_A6BURST     5
`define PCCSIG_B_MEMTYPE     2
`define PCCSIG_B_A5CARD      1
`define PCCSIG_B_A6CARD      0
`define PCCSIG_P_ATTR        0
`define PCCSIG_P_CARDRESET   1
`define PCCSIG_P_REFRESH     2
`define PCCSIG_P_TOPADDR     3
`define PCCSIG_AREA_FIVE     3'h5
`define PCCSIG_AREA_SIX      3'h6
`define PCCSIG_STROBE_CYCLES 2
`endif

// ==== rtl/pccsig_pkg.sv ====
/*
 * pccsig_pkg.sv: types for the card-socket signal map block.
 * assumes pccsig_defs.svh supplies all numeric constants.
 */
package pccsig_pkg;
  typedef enum logic [1:0] {
    PCCSIG_IDLE,
    PCCSIG_STROBE,
    PCCSIG_DONE
  } pccsig_state_t;
  typedef logic [15:0] pccsig_word_t;
endpackage : pccsig_pkg

// ==== verification/pccsig_card_model.sv ====
/*
 * pccsig_card_model.sv: behavioural card in the socket, memory and I/O space.
 * assumes active-low selects and strobes from the socket block, all on sys_clk.
 */
`timescale 1ns/1ps
module pccsig_card_model (
  input  wire logic        sys_clk,
  input  wire logic        area5Sel_n,
  input  wire logic        area6Sel_n,
  input  wire logic        readStrobe_n,
  input  wire logic        writeStrobe_n,
  input  wire logic        ioReadStrobe_n,
  input  wire logic        ioWriteStrobe_n,
  input  wire logic [3:0]  addrLo,
  input  wire logic [15:0] dataOut,
  input  wire logic        dataOe_n,
  input  wire logic        wide16,
  input  wire logic [3:0]  waitLen,
  output logic      [15:0] dataIn,
  output logic             wait_n,
  output logic             ioIs16_n
);
  logic [15:0] mem [16];
  logic [15:0] lastBus = 16'h0000;
  logic [3:0]  waitCnt = 4'h0;
  logic        selected;
  logic        driving;
  assign selected = !area5Sel_n || !area6Sel_n;
  assign driving = selected && (!readStrobe_n || !ioReadStrobe_n);
  // released bus is not left at its last level
  assign dataIn = !dataOe_n ? dataOut : driving ? mem[addrLo] : ~lastBus;
  assign ioIs16_n = !(wide16 && !area6Sel_n);
  always_ff @(posedge sys_clk) begin
    lastBus <= dataIn;
    if (selected && (!writeStrobe_n || !ioWriteStrobe_n)) begin
      mem[addrLo] <= dataOut;
    end
  end
  // wait follows the select at once, else a short strobe ends before it is seen
  assign wait_n = !(selected && waitCnt < waitLen);
  always_ff @(posedge sys_clk) begin
    if (!selected) begin
      waitCnt <= 4'h0;
    end else if (waitCnt < waitLen) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : pccsig_card_model

// ==== verification/test_pccsig_socket.sv ====
/*
 * test_pccsig_socket.sv: self-checking bench for the socket block and its register.
 * assumes one AHB-Lite master and the behavioural card on the socket side.
 */
`timescale 1ns/1ps
module test_pccsig_socket;
  import pccsig_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e;} pccsig_row_t;
  logic sys_clk = 0, reset = 1, manualReset = 0, standby = 0, endianPin = 1, hsel = 1;
  logic hwrite = 0, hreadyout, hresp, cardReq = 0, cardWrite = 0, cardIo = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [28:0] cardAddr = 0;
  logic [24:0] cardA, seenA;
  logic [15:0] cardWdata = 0, cardRdata, cardDIn, cardDOut;
  logic [7:0] seen;
  logic [3:0] waitLen = 4'h0;
  logic cardDone, cardWide, cardAOe_n, cardDOe_n, area_five_select_n, area_six_select_n;
  logic readStrobe_n, lane_one_write_strobe_n, strobeOe_n, mode_pin_three_n, mode_pin_four_n;
  logic card_io_read_strobe_n, card_io_write_strobe_n, ioIs16_n, cardWait_n, wide16 = 0;
  logic readyBusy = 0, statusChange = 0, batteryAudio = 0, cardDetect1_n = 1, cardDetect2_n = 1;
  logic attrSelect_n, cardReset, refresh_n, topAddr;
  int miscompares = 0, nTests = 0, n, n0;
  pccsig_row_t rows [6] = '{'{32'h0, 32'hffff, 32'h3fff}, '{32'h0, 32'h0, 32'h0800},
    '{32'h0, 32'h2aaa, 32'h2aaa}, '{32'h0, 32'h1555, 32'h1d55},
    '{32'h0, 32'hc003, 32'h0803}, '{32'h10, 32'hffff, 32'h0}};
  always #20 sys_clk = ~sys_clk;
  pccsig_socket i_dut (.sys_clk, .reset, .manualReset, .standby, .endianPin, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cardReq, .cardWrite, .cardIo, .cardAddr, .cardWdata, .cardDone, .cardRdata, .cardWide,
    .cardA, .cardAOe_n, .cardDIn, .cardDOut, .cardDOe_n, .area_five_select_n,
    .area_six_select_n, .readStrobe_n, .lane_one_write_strobe_n, .strobeOe_n,
    .mode_pin_three_n, .mode_pin_four_n, .card_io_read_strobe_n, .card_io_write_strobe_n,
    .ioIs16_n, .cardWait_n, .readyBusy, .statusChange, .batteryAudio, .cardDetect1_n,
    .cardDetect2_n, .attrSelect_n, .cardReset, .refresh_n, .topAddr);
  pccsig_card_model i_card (.sys_clk(sys_clk), .area5Sel_n(area_five_select_n),
    .area6Sel_n(area_six_select_n), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(lane_one_write_strobe_n), .ioReadStrobe_n(card_io_read_strobe_n),
    .ioWriteStrobe_n(card_io_write_strobe_n), .addrLo(cardA[3:0]), .dataOut(cardDOut),
    .dataOe_n(cardDOe_n), .wide16(wide16), .waitLen(waitLen), .dataIn(cardDIn),
    .wait_n(cardWait_n), .ioIs16_n(ioIs16_n));
  task chkw(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chkw
  task chkb(input logic g, input logic e);
    chkw({31'h0, g}, {31'h0, e});
  endtask : chkb
  task endt(input string s);
    $display("end of test %s", s);
  endtask : endt
  // held until hready is sampled high at each phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : ahb
  task card(input logic w, input logic io, input logic [28:0] a, input logic [15:0] d);
    cardReq <= 1'b1;
    cardWrite <= w;
    cardIo <= io;
    cardAddr <= a;
    cardWdata <= d;
    seen = 8'h00;
    n = 0;
    @(posedge sys_clk);
    cardReq <= 1'b0;
    while (cardDone !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
      seen = seen | ~{area_five_select_n, area_six_select_n, readStrobe_n, lane_one_write_strobe_n,
        card_io_read_strobe_n, card_io_write_strobe_n, mode_pin_three_n, mode_pin_four_n};
      if (!(area_five_select_n && area_six_select_n)) seenA = cardA;
    end
  endtask : card
  task wrap_up;
    $display("compares %0d miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #(40 * 20000);
    miscompares++;
    wrap_up();
  end
  initial begin
    seenA = 25'h0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ahb(0, 32'h0, 32'h0);
    chkw(r, 32'h0800);
    foreach (rows[i]) begin
      ahb(1, rows[i].a, rows[i].w);
      ahb(0, rows[i].a, 32'h0);
      chkw(r, rows[i].e);
    end
    endt("register");
    ahb(1, 32'h0, 32'h0); // control cleared so neither area is card space for the first access
    card(0, 0, 29'h18000010, 16'h0);
    chkb(n == 60, 1'b1);
    ahb(1, 32'h0, 32'h3);
    card(0, 0, 29'h00000010, 16'h0);
    chkb(n == 60, 1'b1);
    card(1, 0, 29'h14123456, 16'hbeef);
    chkw(seen, 8'h92);
    chkw(seenA, 25'h0123456);
    card(0, 0, 29'h14123456, 16'h0);
    n0 = n;
    chkw(seen, 8'ha2);
    chkw(cardRdata, 16'hbeef);
    card(1, 0, 29'h18000005, 16'h1234);
    card(0, 0, 29'h18000005, 16'h0);
    chkw(seen, 8'h61);
    chkw(cardRdata, 16'h1234);
    endt("memory card");
    wide16 <= 1'b1;
    card(1, 1, 29'h18000009, 16'h5a5a);
    chkw(seen & 8'hcf, 8'h45);
    chkb(cardWide, 1'b1);
    card(0, 1, 29'h18000009, 16'h0);
    chkw(seen & 8'hcf, 8'h49);
    chkw(cardRdata, 16'h5a5a);
    wide16 <= 1'b0;
    card(0, 1, 29'h18000009, 16'h0);
    chkb(cardWide, 1'b0);
    waitLen <= 4'h5;
    card(0, 0, 29'h14123456, 16'h0);
    chkb(n - n0 >= 4 && n - n0 <= 7, 1'b1);
    waitLen <= 4'h0;
    endt("io card and wait");
    standby <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkb(strobeOe_n & cardAOe_n, 1'b1);
    standby <= 1'b0;
    ahb(1, 32'h0, 32'h2003);
    standby <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkb(strobeOe_n | cardAOe_n, 1'b0);
    standby <= 1'b0;
    endt("standby");
    ahb(1, 32'h4, 32'hf);
    repeat (2) @(posedge sys_clk);
    chkw({attrSelect_n, cardReset, refresh_n, topAddr}, 4'h5);
    manualReset <= 1'b1;
    @(posedge sys_clk);
    manualReset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chkw({attrSelect_n, cardReset, refresh_n, topAddr}, 4'ha);
    ahb(0, 32'h0, 32'h0);
    chkw(r, 32'h2803);
    {readyBusy, statusChange, batteryAudio, cardDetect1_n, cardDetect2_n} <= 5'h15;
    repeat (3) @(posedge sys_clk);
    ahb(0, 32'h8, 32'h0);
    chkw(r, 32'h15);
    // lopsided pattern so a swapped bit order shows up
    {readyBusy, statusChange, batteryAudio, cardDetect1_n, cardDetect2_n} <= 5'h03;
    repeat (3) @(posedge sys_clk);
    ahb(0, 32'h8, 32'h0);
    chkw(r, 32'h18);
    endt("ports and manual reset");
    endianPin <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    ahb(0, 32'h0, 32'h0);
    chkw(r, 32'h0);
    endt("second reset");
    wrap_up();
  end
endmodule : test_pccsig_socket
